// *** core/tocfg_top.sv ***
// tocfg_top: temperature correction, second setup register, fail-safe and lock
// assumes an avalon-mm master with 32-bit data, word addresses = register index
//
// Behaviour
// - add signed local correction, quarter degree steps
// - add signed remote two correction likewise
// - lock freezes corrections and setup two
// - overtemperature forces all fans full duty unless setup bit 7 shuts them down
// - limit 0x80 disables that channel's fail-safe
// - full duty until below limit minus hysteresis
// - overtemp pin output may pull low
// - per-channel hysteresis holds minimum duty below start
// - setup bits 0-3 select two-wire fan sensing
// - setup bit 4 turns averaging off
// - setup bit 5 bypasses the 2.5 V attenuator
// - setup bit 6 selects single-channel conversion
// - channel select bits 7:5 choose input
// - test bit 2 lets fan-sense pin start conversions
// - setup bit 7 shuts down, fans off
module tocfg_top #(
  parameter int NUM_FANS = 4,
  parameter int NUM_PWM = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [9:0] raw_local_quarter,
  input wire logic [9:0] raw_remote1_quarter,
  input wire logic [9:0] raw_remote2_quarter,
  input wire logic [7:0] fan_duty_request,
  input wire logic ext_single_channel_convert_clock,
  output tocfg_pkg::tocfg_temps_t temps,
  output logic [NUM_PWM-1:0][7:0] fan_duty,
  output logic [NUM_PWM-1:0] fan_pwm_level_off,
  output logic [NUM_FANS-1:0] fan_two_wire_sense,
  output logic averaging_off,
  output logic attenuator_bypass,
  output logic [2:0] convert_channel,
  output logic convert_start,
  output logic overtemp_pin_out,
  output logic overtemp_pin_oe,
  output logic irq
);
  logic [7:0] local_corr;
  logic [7:0] remote2_corr;
  logic [7:0] setup_two;
  logic [7:0] chan_select;
  logic [7:0] test_two;
  logic [7:0] ctrl;
  logic [2:0][7:0] limits;
  logic [2:0][3:0] hysts;
  logic [2:0][7:0] starts;
  logic [3:0] status;
  logic [3:0] mask;
  logic [2:0] fail;
  logic [2:0] running;
  logic [2:0] above;
  logic [2:0] fail_q;
  logic [2:0][7:0] ch_temp;
  logic wr;
  logic rd;
  logic wr_go;
  logic rd_go;
  logic rd_load;
  logic locked;
  logic [9:0] next_local;
  logic [9:0] next_remote2;
  logic [7:0] slot_cnt;
  logic [7:0] slot_len;
  logic ext_q;
  logic single_channel_convert_pulse;
  logic [3:0] events;
  logic any_fail;

  assign wr = avs_write && !avs_read;
  assign rd = avs_read && !avs_write;
  assign wr_go = wr && !avs_waitrequest;
  assign rd_go = rd && !avs_waitrequest;
  assign rd_load = rd && avs_waitrequest;
  assign locked = ctrl[tocfg_pkg::CTRL_LOCK];

  // one wait state: read data loads while waitrequest is high,
  // so it already stands at the edge where the master sees it low
  always_ff @(posedge clock) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // signed quarter-degree correction, result truncated to whole degrees
  assign next_local = raw_local_quarter + {{2{local_corr[7]}}, local_corr};
  assign next_remote2 = raw_remote2_quarter + {{2{remote2_corr[7]}}, remote2_corr};

  always_ff @(posedge clock) begin
    if (rst) begin
      temps <= '0;
    end else begin
      temps.local_temp <= next_local[9:2];
      temps.remote1_temp <= raw_remote1_quarter[9:2];
      temps.remote2_temp <= next_remote2[9:2];
    end
  end

  // channel order: 0 remote1, 1 local, 2 remote2
  assign ch_temp[0] = temps.remote1_temp;
  assign ch_temp[1] = temps.local_temp;
  assign ch_temp[2] = temps.remote2_temp;

  // lock only ever sets; clearing it needs a reset, by design
  always_ff @(posedge clock) begin
    if (rst) begin
      local_corr <= tocfg_pkg::RST_CORR;
      remote2_corr <= tocfg_pkg::RST_CORR;
      setup_two <= tocfg_pkg::RST_SETUP;
      limits <= {3{tocfg_pkg::RST_LIMIT}};
      hysts <= {3{tocfg_pkg::RST_HYST}};
      starts <= {3{tocfg_pkg::RST_START}};
    end else if (wr_go && !locked) begin
      case (avs_address)
        tocfg_pkg::IDX_LOCAL_CORR: local_corr <= avs_writedata[7:0];
        tocfg_pkg::IDX_REMOTE2_CORR: remote2_corr <= avs_writedata[7:0];
        tocfg_pkg::IDX_SETUP_TWO: setup_two <= avs_writedata[7:0];
        tocfg_pkg::IDX_LIMITS: limits <= avs_writedata[23:0];
        tocfg_pkg::IDX_HYST: hysts <= avs_writedata[11:0];
        tocfg_pkg::IDX_START: starts <= avs_writedata[23:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      chan_select <= 8'h00;
      test_two <= 8'h00;
      ctrl <= 8'h00;
      mask <= 4'h0;
    end else if (wr_go) begin
      case (avs_address)
        tocfg_pkg::IDX_CHAN_SELECT: chan_select <= avs_writedata[7:0];
        tocfg_pkg::IDX_TEST_TWO: test_two <= avs_writedata[7:0];
        tocfg_pkg::IDX_CTRL: ctrl <= avs_writedata[7:0] | {7'h00, locked};
        tocfg_pkg::IDX_MASK: mask <= avs_writedata[3:0];
        default: ;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      tocfg_chan u_chan (
        .clock(clock),
        .rst(rst),
        .temp(ch_temp[gi]),
        .limit(limits[gi]),
        .start(starts[gi]),
        .hyst(hysts[gi]),
        .fail(fail[gi]),
        .running(running[gi]),
        .above(above[gi])
      );
    end
  endgenerate

  assign any_fail = |fail;

  // shutdown beats fail-safe: fans off is what software asked
  always_ff @(posedge clock) begin
    if (rst) begin
      fan_duty <= '0;
      fan_pwm_level_off <= '0;
    end else begin
      for (int i = 0; i < NUM_PWM; i++) begin
        fan_pwm_level_off[i] <= ctrl[tocfg_pkg::CTRL_POL];
        if (setup_two[tocfg_pkg::SETUP_SHUTDOWN_REQUEST]) begin
          fan_duty[i] <= tocfg_pkg::DUTY_OFF;
        end else if (any_fail) begin
          fan_duty[i] <= tocfg_pkg::DUTY_FULL;
        end else if (running[i]) begin
          fan_duty[i] <= fan_duty_request;
        end else begin
          fan_duty[i] <= tocfg_pkg::DUTY_OFF;
        end
      end
    end
  end

  // setup bits drive the converter and sense muxes directly
  always_ff @(posedge clock) begin
    if (rst) begin
      fan_two_wire_sense <= '0;
      averaging_off <= 1'b0;
      attenuator_bypass <= 1'b0;
      convert_channel <= tocfg_pkg::SEL_2V5;
      overtemp_pin_out <= 1'b0;
      overtemp_pin_oe <= 1'b0;
    end else begin
      fan_two_wire_sense <= setup_two[NUM_FANS-1:0];
      averaging_off <= setup_two[tocfg_pkg::SETUP_AVG_OFF];
      attenuator_bypass <= setup_two[tocfg_pkg::SETUP_ATTENUATOR_BYPASS];
      convert_channel <= setup_two[tocfg_pkg::SETUP_SINGLE] ? chan_select[7:5] : 3'b000;
      overtemp_pin_out <= 1'b0;
      overtemp_pin_oe <= ctrl[tocfg_pkg::CTRL_OT_OUT] && (|above);
    end
  end

  // conversion slot pacing; averaging off shortens the slot
  assign slot_len = setup_two[tocfg_pkg::SETUP_AVG_OFF] ?
                    8'(tocfg_pkg::SLOT_CYC_FAST - 1) : 8'(tocfg_pkg::SLOT_CYC_AVG - 1);

  always_ff @(posedge clock) begin
    if (rst) begin
      slot_cnt <= 8'h00;
      ext_q <= 1'b0;
      convert_start <= 1'b0;
    end else begin
      ext_q <= ext_single_channel_convert_clock;
      if (test_two[tocfg_pkg::TEST_EXT_SINGLE_CHANNEL_CONVERT]) begin
        convert_start <= ext_single_channel_convert_clock && !ext_q;
        slot_cnt <= 8'h00;
      end else if (slot_cnt >= slot_len) begin
        convert_start <= 1'b1;
        slot_cnt <= 8'h00;
      end else begin
        convert_start <= 1'b0;
        slot_cnt <= slot_cnt + 8'h01;
      end
    end
  end

  // events: rising fail-safe per channel, any accepted write while locked
  always_ff @(posedge clock) begin
    if (rst) begin
      fail_q <= 3'b000;
    end else begin
      fail_q <= fail;
    end
  end
  assign events = {wr_go && locked, fail & ~fail_q};

  // set beats the read clear
  always_ff @(posedge clock) begin
    if (rst) begin
      status <= 4'h0;
    end else if (rd_go && avs_address == tocfg_pkg::IDX_STATUS) begin
      status <= events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status | events) & ~mask);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_load) begin
      case (avs_address)
        tocfg_pkg::IDX_LOCAL_CORR: avs_readdata <= {24'h000000, local_corr};
        tocfg_pkg::IDX_REMOTE2_CORR: avs_readdata <= {24'h000000, remote2_corr};
        tocfg_pkg::IDX_SETUP_TWO: avs_readdata <= {24'h000000, setup_two};
        tocfg_pkg::IDX_CHAN_SELECT: avs_readdata <= {24'h000000, chan_select};
        tocfg_pkg::IDX_TEST_TWO: avs_readdata <= {24'h000000, test_two};
        tocfg_pkg::IDX_CTRL: avs_readdata <= {24'h000000, ctrl};
        tocfg_pkg::IDX_LIMITS: avs_readdata <= {8'h00, limits};
        tocfg_pkg::IDX_HYST: avs_readdata <= {20'h00000, hysts};
        tocfg_pkg::IDX_START: avs_readdata <= {8'h00, starts};
        // events of the load cycle are reported, not lost to the clear
        tocfg_pkg::IDX_STATUS: avs_readdata <= {28'h0000000, status | events};
        tocfg_pkg::IDX_MASK: avs_readdata <= {28'h0000000, mask};
        tocfg_pkg::IDX_REPORT: avs_readdata <= {8'h00, temps};
        tocfg_pkg::IDX_DUTY: avs_readdata <= {15'h0000, fail, running, above, fan_duty[0]};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // tocfg_top

// *** shared/tocfg_pkg.sv ***
// tocfg_pkg: register map, field positions, reset values and shared types
// assumes a byte-wide register space reached through a 32-bit avalon slave
package tocfg_pkg;
  // register indices; printed offsets are not multiples of four
  localparam logic [7:0] IDX_LOCAL_CORR = 8'h71;
  localparam logic [7:0] IDX_REMOTE2_CORR = 8'h72;
  localparam logic [7:0] IDX_SETUP_TWO = 8'h73;
  localparam logic [7:0] IDX_CHAN_SELECT = 8'h55;
  localparam logic [7:0] IDX_TEST_TWO = 8'h7f;
  localparam logic [7:0] IDX_CTRL = 8'hc0;
  localparam logic [7:0] IDX_LIMITS = 8'hc1;
  localparam logic [7:0] IDX_HYST = 8'hc2;
  localparam logic [7:0] IDX_START = 8'hc3;
  localparam logic [7:0] IDX_STATUS = 8'hc4;
  localparam logic [7:0] IDX_MASK = 8'hc5;
  localparam logic [7:0] IDX_REPORT = 8'hc6;
  localparam logic [7:0] IDX_DUTY = 8'hc7;
  // setup two, test two and control fields
  localparam int SETUP_AVG_OFF = 4;
  localparam int SETUP_ATTENUATOR_BYPASS = 5;
  localparam int SETUP_SINGLE = 6;
  localparam int SETUP_SHUTDOWN_REQUEST = 7;
  localparam int TEST_EXT_SINGLE_CHANNEL_CONVERT = 2;
  localparam int CTRL_LOCK = 0;
  localparam int CTRL_OT_OUT = 1;
  localparam int CTRL_POL = 2;
  // reset values and fixed codes
  localparam logic [7:0] RST_CORR = 8'h00;
  localparam logic [7:0] RST_SETUP = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'h64;
  localparam logic [7:0] RST_START = 8'h5a;
  localparam logic [3:0] RST_HYST = 4'h4;
  localparam logic [7:0] LIMIT_OFF = 8'h80;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] DUTY_OFF = 8'h00;
  localparam logic [2:0] SEL_2V5 = 3'b000;
  localparam logic [2:0] SEL_SUPPLY = 3'b010;
  localparam logic [2:0] SEL_REMOTE1 = 3'b101;
  localparam logic [2:0] SEL_LOCAL = 3'b110;
  localparam logic [2:0] SEL_REMOTE2 = 3'b111;
  // conversion slot timing
  localparam int SLOT_NS_AVG = 1000;
  localparam int SLOT_NS_FAST = 200;
  localparam int CLK_NS = 10;
  localparam int SLOT_CYC_AVG = SLOT_NS_AVG / CLK_NS;
  localparam int SLOT_CYC_FAST = SLOT_NS_FAST / CLK_NS;
  typedef struct packed {
    logic [7:0] local_temp;
    logic [7:0] remote1_temp;
    logic [7:0] remote2_temp;
  } tocfg_temps_t;
  typedef enum logic [1:0] {
    TOCFG_COOL = 2'b00,
    TOCFG_FAIL = 2'b01
  } tocfg_safe_t;
endpackage

// *** core/tocfg_chan.sv ***
// tocfg_chan: per-channel overtemperature fail-safe and start hysteresis
// assumes temperatures as unsigned whole degrees, already corrected
module tocfg_chan (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] temp,
  input wire logic [7:0] limit,
  input wire logic [7:0] start,
  input wire logic [3:0] hyst,
  output logic fail,
  output logic running,
  output logic above
);
  tocfg_pkg::tocfg_safe_t state;
  logic [8:0] ot_release;
  logic [8:0] start_release;
  assign ot_release = {1'b0, limit} - {5'h00, hyst};
  assign start_release = {1'b0, start} - {5'h00, hyst};
  // limit 0x80 turns the fail-safe off
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= tocfg_pkg::TOCFG_COOL;
    end else begin
      case (state)
        tocfg_pkg::TOCFG_COOL: begin
          if (limit != tocfg_pkg::LIMIT_OFF && temp > limit) begin
            state <= tocfg_pkg::TOCFG_FAIL;
          end
        end
        tocfg_pkg::TOCFG_FAIL: begin
          if (limit == tocfg_pkg::LIMIT_OFF || {1'b0, temp} < ot_release) begin
            state <= tocfg_pkg::TOCFG_COOL;
          end
        end
        default: state <= tocfg_pkg::TOCFG_COOL;
      endcase
    end
  end
  assign fail = (state == tocfg_pkg::TOCFG_FAIL);
  // start hysteresis keeps minimum duty while temp stays above start minus hyst
  always_ff @(posedge clock) begin
    if (rst) begin
      running <= 1'b0;
    end else if (temp > start) begin
      running <= 1'b1;
    end else if ({1'b0, temp} <= start_release) begin
      running <= 1'b0;
    end
  end
  // pin asserts one whole degree above limit; quarter bits are dropped before the compare
  assign above = (limit != tocfg_pkg::LIMIT_OFF) && (temp > limit);
endmodule // tocfg_chan

// *** tb/tocfg_monitor.sv ***
// tocfg_monitor: port-level assertions for tocfg_top
// assumes a bind from the bench top; sees only top ports
module tocfg_monitor #(
  parameter int NUM_FANS = 4,
  parameter int NUM_PWM = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [NUM_PWM-1:0][7:0] fan_duty,
  input wire logic [NUM_PWM-1:0] fan_pwm_level_off,
  input wire logic [NUM_FANS-1:0] fan_two_wire_sense,
  input wire logic averaging_off,
  input wire logic attenuator_bypass,
  input wire logic [2:0] convert_channel,
  input wire logic overtemp_pin_out
);
  logic locked;
  logic ctrl_wr;
  logic unmapped;
  assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == tocfg_pkg::IDX_CTRL;
  assign unmapped = !(avs_address inside {8'h55, 8'h7f, [8'h71:8'h73], [8'hc0:8'hc7]});
  // lock shadow only sets; a second reset is the only way out
  always_ff @(posedge clock) begin
    if (rst) begin
      locked <= 1'b0;
    end else if (ctrl_wr && avs_writedata[tocfg_pkg::CTRL_LOCK]) begin
      locked <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_setup_wr;
    avs_write && !avs_waitrequest && avs_address == tocfg_pkg::IDX_SETUP_TWO && !locked;
  endsequence
  sequence s_setup_frozen;
    avs_write && !avs_waitrequest && avs_address == tocfg_pkg::IDX_SETUP_TWO && locked;
  endsequence
  // register then output flop: fields show two edges after acceptance
  property p_fields;
    s_setup_wr |-> ##2 fan_two_wire_sense == $past(avs_writedata[3:0], 2)
      && averaging_off == $past(avs_writedata[4], 2)
      && attenuator_bypass == $past(avs_writedata[5], 2);
  endproperty
  property p_frozen;
    s_setup_frozen |=> $stable(fan_two_wire_sense) [*2];
  endproperty
  property p_single_off;
    s_setup_wr ##0 !avs_writedata[6] |-> ##2 convert_channel == 3'b000;
  endproperty
  property p_shutdown;
    s_setup_wr ##0 avs_writedata[7] |-> ##2 fan_duty == '0;
  endproperty
  property p_unmapped;
    avs_read && !avs_waitrequest && unmapped |-> avs_readdata == 32'h0;
  endproperty
  property p_pin_out;
    overtemp_pin_out == 1'b0;
  endproperty
  property p_polarity;
    $changed(fan_pwm_level_off) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
  endproperty
  property p_wait_once;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_fields: assert property (p_fields) else $error("setup fields wrong");
  a_frozen: assert property (p_frozen) else $error("locked setup changed");
  a_single_off: assert property (p_single_off) else $error("channel not cleared");
  a_shutdown: assert property (p_shutdown) else $error("fans not off");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_pin_out: assert property (p_pin_out) else $error("pin driven high");
  a_polarity: assert property (p_polarity) else $error("polarity moved alone");
  a_wait_once: assert property (p_wait_once) else $error("no answer after one wait state");
endmodule // tocfg_monitor

// *** tb/test_thermal_offset_and_config_two.sv ***
// test_thermal_offset_and_config_two: directed register-level bench
// assumes avalon word address = register index, master waits on waitrequest
module test_thermal_offset_and_config_two;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, avs_read, avs_write, avs_waitrequest, ext_single_channel_convert_clock;
  logic [7:0] avs_address, fan_duty_request;
  logic [31:0] avs_writedata, avs_readdata;
  logic [9:0] raw_local_quarter, raw_remote1_quarter, raw_remote2_quarter;
  tocfg_pkg::tocfg_temps_t temps;
  logic [2:0][7:0] fan_duty;
  logic [2:0] fan_pwm_level_off, convert_channel;
  logic [3:0] fan_two_wire_sense;
  logic averaging_off, attenuator_bypass, convert_start;
  logic overtemp_pin_out, overtemp_pin_oe, irq;
  int n_checks, miscompares, cycles;
  logic [2:0] codes [5] = '{3'b000, 3'b010, 3'b101, 3'b110, 3'b111};
  wire full = (fan_duty === {3{8'hff}});
  tocfg_top dut (
    .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .raw_local_quarter(raw_local_quarter),
    .raw_remote1_quarter(raw_remote1_quarter), .raw_remote2_quarter(raw_remote2_quarter),
    .fan_duty_request(fan_duty_request), .ext_single_channel_convert_clock(ext_single_channel_convert_clock), .temps(temps),
    .fan_duty(fan_duty), .fan_pwm_level_off(fan_pwm_level_off),
    .fan_two_wire_sense(fan_two_wire_sense), .averaging_off(averaging_off),
    .attenuator_bypass(attenuator_bypass), .convert_channel(convert_channel),
    .convert_start(convert_start), .overtemp_pin_out(overtemp_pin_out),
    .overtemp_pin_oe(overtemp_pin_oe), .irq(irq)
  );
  task automatic summarize();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // extra edge after release keeps two requests from sharing a time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    chk(avs_readdata, e);
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  // slow enough for every channel to get a conversion slot
  task automatic settle();
    repeat (400) @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    raw_local_quarter = 10'd200;
    raw_remote1_quarter = 10'd0;
    raw_remote2_quarter = 10'd0;
    fan_duty_request = 8'h40;
    ext_single_channel_convert_clock = 1'b0;
    n_checks = 0;
    miscompares = 0;
    cycles = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(8'h71, 32'h0);
    rd(8'h72, 32'h0);
    rd(8'h73, 32'h0);
    rd(8'h10, 32'h0);
    // minus one degree on local, plus two on remote two
    wr(8'h71, 32'hfc);
    wr(8'h72, 32'h08);
    raw_local_quarter <= 10'd400;
    raw_remote2_quarter <= 10'd200;
    settle();
    chk(32'(temps.local_temp), 32'd99);
    chk(32'(temps.remote2_temp), 32'd52);
    rd(8'h71, 32'hfc);
    wr(8'h73, 32'h7f);
    @(negedge clock);
    chk(32'({attenuator_bypass, averaging_off, fan_two_wire_sense}), 32'h3f);
    for (int i = 0; i < 5; i++) begin
      wr(8'h55, 32'({codes[i], 5'h00}));
      repeat (2) @(posedge clock);
      chk(32'(convert_channel), 32'(codes[i]));
    end
    wr(8'h73, 32'h00);
    repeat (2) @(posedge clock);
    chk(32'(convert_channel), 32'h0);
    chk(32'(fan_duty), 32'h004000);
    wr(8'h73, 32'h80);
    repeat (2) @(posedge clock);
    chk(32'(fan_duty), 32'h0);
    wr(8'h73, 32'h00);
    // overtemp pin as output, off polarity high
    wr(8'hc0, 32'h06);
    wr(8'hc2, 32'h444);
    @(negedge clock);
    chk(32'(fan_pwm_level_off), 32'h7);
    raw_local_quarter <= 10'd408;
    settle();
    chk(32'(full), 32'h1);
    chk(32'(overtemp_pin_oe), 32'h1);
    chk(32'(irq), 32'h1);
    rd(8'hc4, 32'h02);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0);
    raw_local_quarter <= 10'd396;
    settle();
    chk(32'(full), 32'h1);
    raw_local_quarter <= 10'd384;
    settle();
    chk(32'(full), 32'h0);
    wr(8'hc5, 32'h02);
    raw_local_quarter <= 10'd408;
    settle();
    chk(32'(irq), 32'h0);
    rd(8'hc4, 32'h02);
    wr(8'hc1, 32'h648064);
    raw_local_quarter <= 10'd444;
    settle();
    chk(32'(full), 32'h0);
    wr(8'hc0, 32'h07);
    wr(8'h71, 32'h55);
    wr(8'h73, 32'h80);
    rd(8'h71, 32'hfc);
    rd(8'h73, 32'h00);
    rd(8'hc4, 32'h08);
    summarize();
  end
endmodule // test_thermal_offset_and_config_two
bind tocfg_top tocfg_monitor #(.NUM_FANS(NUM_FANS), .NUM_PWM(NUM_PWM)) u_mon (
  .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .fan_duty(fan_duty),
  .fan_pwm_level_off(fan_pwm_level_off), .fan_two_wire_sense(fan_two_wire_sense),
  .averaging_off(averaging_off), .attenuator_bypass(attenuator_bypass),
  .convert_channel(convert_channel), .overtemp_pin_out(overtemp_pin_out)
);
